// ### verilog/bcs_pkg.sv
// Purpose: constants for the battery charge sequencer
// Assumes: apb slave, 100 MHz pclk, analog comparators on pins
// Notes on behaviour
// - the first supply rising above undervoltage readies the bus, registers reload defaults.
// - power good needs input over battery+250mV, input above uvlo, no otg.
// - after power good, pulse source detection if enabled, then enable converter.
// - input conditions watched always; any failing suspends the charge cycle.
// - below min system+60mV regulate at max plus offset, battery switch linear while charging.
// - system offset is 50mV or 100mV by config bit 0.
// - suspended or complete: regulate at offset above max of minimum and battery.
// - qualified input and battery under 2.1V gives fixed 128mA trickle.
// - pre-charge until exit threshold; pre timer expiry ends cycle with fault.
// - pre-charge current comes from bits 7:4 of current config.
// - above exit threshold (bit 1) fast charge at bits 7:2 current.
// - at full voltage (bits 7:2) enter constant voltage, current tapers.
// - complete when current reaches termination bits 3:0, only if bit 7 set.
// - safety timer expiry before termination ends cycle with timeout fault.
// - junction regulation threshold from bits 1:0; current reduced to hold it.
// - new cycle on replug, enable or ovp recovery, with no blocking faults.
// - after completion, battery under recharge threshold restarts charging.
// - charging enabled only with config bits 5:4 at 01 and permit pin low.
// - battery over full+160mV suspends charging at once and flags fault.
package bcs_pkg;
  // register indices; byte address is four times the index
  localparam logic [4:0] IDX_SYS_CFG  = 5'h01;
  localparam logic [4:0] IDX_FAST_I   = 5'h02;
  localparam logic [4:0] IDX_CHG_I    = 5'h03;
  localparam logic [4:0] IDX_VOLT     = 5'h04;
  localparam logic [4:0] IDX_TIMER    = 5'h05;
  localparam logic [4:0] IDX_THERM    = 5'h06;
  localparam logic [4:0] IDX_STATUS   = 5'h08;
  // reset values
  localparam logic [7:0] RST_SYS_CFG  = 8'h1a;
  localparam logic [7:0] RST_FAST_I   = 8'h60;
  localparam logic [7:0] RST_CHG_I    = 8'h11;
  localparam logic [7:0] RST_VOLT     = 8'ha2;
  localparam logic [7:0] RST_TIMER    = 8'h80;
  localparam logic [7:0] RST_THERM    = 8'h03;
  // field positions
  localparam int SYS_OFS_BIT  = 0;
  localparam int SYS_MIN_LSB  = 1;
  localparam int SYS_CHG_LSB  = 4;
  localparam int FAST_I_LSB   = 2;
  localparam int PRE_I_LSB    = 4;
  localparam int TERM_I_LSB   = 0;
  localparam int FULL_V_LSB   = 2;
  localparam int PRE_SEL_BIT  = 1;
  localparam int TERM_EN_BIT  = 7;
  localparam int TJ_LSB       = 0;
  localparam int DPDM_EN_BIT  = 7;
  localparam logic [1:0] CHG_CFG_EN  = 2'h1;
  localparam logic [1:0] CHG_CFG_OTG = 2'h2;
  // pin comparator index in the synchronised bank
  localparam int PIN_VIN_UV   = 0;
  localparam int PIN_BAT_UV   = 1;
  localparam int PIN_VIN_HDRM = 2;
  localparam int PIN_SHORT    = 3;
  localparam int PIN_PRE_EXIT = 4;
  localparam int PIN_FULL     = 5;
  localparam int PIN_TERM     = 6;
  localparam int PIN_RECHG    = 7;
  localparam int PIN_OVP      = 8;
  localparam int PIN_SYSMIN   = 9;
  localparam int PIN_NTC      = 10;
  localparam int PIN_PERMIT_N = 11;
  localparam int PIN_TJ_HOT   = 12;
  localparam int NPIN         = 13;
  // timing
  localparam int CLK_KHZ      = 100000;
  localparam int PRE_TO_MS    = 30;
  localparam int SAFE_TO_MS   = 40;
  localparam int PRE_TO_CYC   = PRE_TO_MS * CLK_KHZ;
  localparam int SAFE_TO_CYC  = SAFE_TO_MS * CLK_KHZ;
  // current mode codes
  localparam logic [1:0] IMODE_OFF  = 2'h0;
  localparam logic [1:0] IMODE_TRK  = 2'h1;
  localparam logic [1:0] IMODE_PRE  = 2'h2;
  localparam logic [1:0] IMODE_FAST = 2'h3;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_TRK = 7'h02, ST_PRE = 7'h04, ST_CC = 7'h08,
    ST_CV = 7'h10, ST_DONE = 7'h20, ST_FAULT = 7'h40
  } bcs_state_e;
endpackage

// ### verilog/bcs_top.sv
// Purpose: charge phase sequencer with apb register file
// Assumes: comparator pins are asynchronous, pready never stalls
// Notes: analog loops sit outside; this block selects their targets
`timescale 1ns/10ps
module bcs_top #(
  parameter int unsigned PRE_TO  = bcs_pkg::PRE_TO_CYC,
  parameter int unsigned SAFE_TO = bcs_pkg::SAFE_TO_CYC
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    clk_en,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [bcs_pkg::NPIN-1:0] pins_async,
  output logic                         serial_ready,
  output logic                         power_good,
  output logic                         dpdm_start,
  output logic                         buck_enable,
  output logic      [1:0]              chg_i_mode,
  output logic      [5:0]              chg_i_code,
  output logic                         cv_mode,
  output logic      [5:0]              full_v_code,
  output logic                         pre_exit_sel,
  output logic      [3:0]              term_i_code,
  output logic      [2:0]              sys_min_code,
  output logic                         sys_offset_sel,
  output logic                         sys_track_max,
  output logic                         batfet_linear,
  output logic      [1:0]              tj_limit_sel,
  output logic                         thermal_reduce
);
  import bcs_pkg::*;

  // two-flop synchroniser for every comparator pin
  logic [NPIN-1:0] s1_q, s2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
    end else if (clk_en) begin
      s1_q <= pins_async;
      s2_q <= s1_q;
    end
  end

  logic sup_ok, pg_raw, chg_en;
  logic [7:0] cfg_q, fast_q, chgi_q, volt_q, tmr_q, thm_q;
  assign sup_ok = s2_q[PIN_VIN_UV] | s2_q[PIN_BAT_UV];
  // otg code in the enable field blocks power good
  assign pg_raw = s2_q[PIN_VIN_HDRM] & s2_q[PIN_VIN_UV]
                & (cfg_q[SYS_CHG_LSB +: 2] != CHG_CFG_OTG);
  assign chg_en = (cfg_q[SYS_CHG_LSB +: 2] == CHG_CFG_EN)
                & ~s2_q[PIN_PERMIT_N];

  // edge history for supply, power good, enable and ovp
  logic sup_d, pg_d, en_d, ovp_d, buck_d;
  logic sup_q, pg_q, en_q, ovp_q, buck_q;
  logic sup_rise, pg_rise;
  assign sup_rise = sup_ok & ~sup_q;
  assign pg_rise  = pg_raw & ~pg_q;
  always_comb begin
    sup_d  = sup_ok;
    pg_d   = pg_raw;
    en_d   = chg_en;
    ovp_d  = s2_q[PIN_OVP];
    buck_d = pg_q & pg_raw; // converter follows detection start by a cycle
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_q  <= 1'b0;
      pg_q   <= 1'b0;
      en_q   <= 1'b0;
      ovp_q  <= 1'b0;
      buck_q <= 1'b0;
    end else if (clk_en) begin
      sup_q  <= sup_d;
      pg_q   <= pg_d;
      en_q   <= en_d;
      ovp_q  <= ovp_d;
      buck_q <= buck_d;
    end
  end

  // apb decode: zero wait states, unmapped index errors
  logic [4:0] idx;
  logic       hit, setup, wr;
  assign idx   = paddr[6:2];
  assign hit   = (paddr[11:7] == 5'h00) && (paddr[1:0] == 2'h0)
              && (idx inside {IDX_SYS_CFG, IDX_FAST_I, IDX_CHG_I, IDX_VOLT,
                              IDX_TIMER, IDX_THERM, IDX_STATUS});
  assign setup = psel & ~penable;
  assign wr    = psel & penable & pwrite & hit & clk_en;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // register file, reloaded when the first supply comes up
  logic [7:0] cfg_d, fast_d, chgi_d, volt_d, tmr_d, thm_d;
  always_comb begin
    cfg_d  = cfg_q;
    fast_d = fast_q;
    chgi_d = chgi_q;
    volt_d = volt_q;
    tmr_d  = tmr_q;
    thm_d  = thm_q;
    if (sup_rise) begin
      cfg_d  = RST_SYS_CFG;
      fast_d = RST_FAST_I;
      chgi_d = RST_CHG_I;
      volt_d = RST_VOLT;
      tmr_d  = RST_TIMER;
      thm_d  = RST_THERM;
    end else if (wr) begin
      case (idx)
        IDX_SYS_CFG: cfg_d  = pwdata[7:0];
        IDX_FAST_I:  fast_d = pwdata[7:0];
        IDX_CHG_I:   chgi_d = pwdata[7:0];
        IDX_VOLT:    volt_d = pwdata[7:0];
        IDX_TIMER:   tmr_d  = pwdata[7:0];
        IDX_THERM:   thm_d  = pwdata[7:0];
        default:     cfg_d  = cfg_q; // status is read only
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q  <= RST_SYS_CFG;
      fast_q <= RST_FAST_I;
      chgi_q <= RST_CHG_I;
      volt_q <= RST_VOLT;
      tmr_q  <= RST_TIMER;
      thm_q  <= RST_THERM;
    end else if (clk_en) begin
      cfg_q  <= cfg_d;
      fast_q <= fast_d;
      chgi_q <= chgi_d;
      volt_q <= volt_d;
      tmr_q  <= tmr_d;
      thm_q  <= thm_d;
    end
  end

  // charge sequencer with faults and timers
  bcs_state_e st_q, st_d;
  logic [31:0] pre_cnt_q, pre_cnt_d, safe_cnt_q, safe_cnt_d;
  logic pre_to_q, pre_to_d, safe_to_q, safe_to_d;
  logic start_q, start_d, charging, blocked, trig;
  assign charging = st_q inside {ST_TRK, ST_PRE, ST_CC, ST_CV};
  // replug, fresh enable or ovp recovery request a cycle
  assign trig = pg_rise | (chg_en & ~en_q) | (~s2_q[PIN_OVP] & ovp_q);
  assign blocked = s2_q[PIN_NTC] | pre_to_q | safe_to_q | s2_q[PIN_OVP]
                 | batfet_forced_off(thm_q);

  // batfet force-off bit shares the thermal register
  function automatic logic batfet_forced_off(input logic [7:0] r);
    batfet_forced_off = r[6];
  endfunction

  always_comb begin
    st_d       = st_q;
    start_d    = start_q | trig; // a new trigger wins over consumption except in ST_DONE
    pre_cnt_d  = (st_q == ST_PRE) ? pre_cnt_q + 32'h1 : 32'h0;
    safe_cnt_d = charging ? safe_cnt_q + 32'h1 : 32'h0;
    pre_to_d   = pre_to_q;
    safe_to_d  = safe_to_q;
    if (pg_rise | (chg_en & ~en_q)) begin
      pre_to_d  = 1'b0; // replug or re-enable clears timeouts
      safe_to_d = 1'b0;
    end
    if (sup_rise) begin
      st_d    = ST_IDLE;
      start_d = 1'b1;
    end else if (charging & (~pg_raw | ~chg_en | s2_q[PIN_OVP] | s2_q[PIN_NTC])) begin
      st_d    = ST_IDLE;
      start_d = start_q | trig | ~pg_raw;
    end else begin
      case (st_q)
        ST_IDLE, ST_FAULT: begin
          if (start_q & pg_raw & chg_en & ~blocked & ~trig) begin
            st_d    = s2_q[PIN_SHORT] ? ST_TRK : ST_PRE;
            start_d = 1'b0;
          end
        end
        ST_TRK: if (!s2_q[PIN_SHORT]) st_d = ST_PRE;
        ST_PRE: begin
          if (s2_q[PIN_PRE_EXIT]) st_d = ST_CC;
          else if (pre_cnt_q >= PRE_TO - 32'h1) begin
            st_d     = ST_FAULT;
            pre_to_d = 1'b1;
          end
        end
        ST_CC: if (s2_q[PIN_FULL]) st_d = ST_CV;
        ST_CV: begin
          if (tmr_q[TERM_EN_BIT] & s2_q[PIN_TERM]) st_d = ST_DONE;
        end
        ST_DONE: begin
          if (s2_q[PIN_RECHG]) start_d = 1'b1;
          if (start_q & pg_raw & chg_en & ~blocked) begin
            st_d    = s2_q[PIN_SHORT] ? ST_TRK : ST_PRE;
            start_d = 1'b0;
          end
        end
        default: st_d = ST_IDLE;
      endcase
      if (charging & (safe_cnt_q >= SAFE_TO - 32'h1) & (st_d != ST_DONE)) begin
        st_d      = ST_FAULT;
        safe_to_d = 1'b1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q       <= ST_IDLE;
      start_q    <= 1'b0;
      pre_cnt_q  <= 32'h0;
      safe_cnt_q <= 32'h0;
      pre_to_q   <= 1'b0;
      safe_to_q  <= 1'b0;
    end else if (clk_en) begin
      st_q       <= st_d;
      start_q    <= start_d;
      pre_cnt_q  <= pre_cnt_d;
      safe_cnt_q <= safe_cnt_d;
      pre_to_q   <= pre_to_d;
      safe_to_q  <= safe_to_d;
    end
  end

  // phase code seen by software
  function automatic logic [2:0] phase_code(input bcs_state_e s);
    case (s)
      ST_TRK:   phase_code = 3'h1;
      ST_PRE:   phase_code = 3'h2;
      ST_CC:    phase_code = 3'h3;
      ST_CV:    phase_code = 3'h4;
      ST_DONE:  phase_code = 3'h5;
      ST_FAULT: phase_code = 3'h6;
      default:  phase_code = 3'h0;
    endcase
  endfunction

  logic [7:0] status;
  assign status = {phase_code(st_q), safe_to_q, pre_to_q, pg_raw,
                   s2_q[PIN_OVP], s2_q[PIN_NTC]};

  // read data and loop targets, registered
  logic [31:0] rd_d, rd_q;
  logic [1:0]  imode_d;
  logic [5:0]  icode_d;
  logic        dpdm_d, track_d, lin_d, thr_d;
  always_comb begin
    rd_d = rd_q;
    if (setup & clk_en) begin
      case (idx)
        IDX_SYS_CFG: rd_d = {24'h0, cfg_q};
        IDX_FAST_I:  rd_d = {24'h0, fast_q};
        IDX_CHG_I:   rd_d = {24'h0, chgi_q};
        IDX_VOLT:    rd_d = {24'h0, volt_q};
        IDX_TIMER:   rd_d = {24'h0, tmr_q};
        IDX_THERM:   rd_d = {24'h0, thm_q};
        IDX_STATUS:  rd_d = {24'h0, status};
        default:     rd_d = 32'h0;
      endcase
    end
    imode_d = IMODE_OFF;
    icode_d = 6'h0;
    case (st_q)
      ST_TRK: imode_d = IMODE_TRK; // fixed current in the analog stage
      ST_PRE: begin
        imode_d = IMODE_PRE;
        icode_d = {2'h0, chgi_q[PRE_I_LSB +: 4]};
      end
      ST_CC, ST_CV: begin
        imode_d = IMODE_FAST;
        icode_d = fast_q[FAST_I_LSB +: 6];
      end
      default: imode_d = IMODE_OFF;
    endcase
    dpdm_d  = pg_rise & thm_q[DPDM_EN_BIT];
    // max(min,batt)+offset when low battery or not charging
    track_d = s2_q[PIN_SYSMIN] | ~charging;
    lin_d   = s2_q[PIN_SYSMIN] & charging;
    thr_d   = charging & s2_q[PIN_TJ_HOT];
  end
  logic [1:0] imode_q;
  logic [5:0] icode_q;
  logic       dpdm_q, track_q, lin_q, thr_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q    <= 32'h0;
      imode_q <= IMODE_OFF;
      icode_q <= 6'h0;
      dpdm_q  <= 1'b0;
      track_q <= 1'b1;
      lin_q   <= 1'b0;
      thr_q   <= 1'b0;
    end else if (clk_en) begin
      rd_q    <= rd_d;
      imode_q <= imode_d;
      icode_q <= icode_d;
      dpdm_q  <= dpdm_d;
      track_q <= track_d;
      lin_q   <= lin_d;
      thr_q   <= thr_d;
    end
  end

  assign prdata         = rd_q;
  assign serial_ready   = sup_q;
  assign power_good     = pg_q;
  assign dpdm_start     = dpdm_q;
  assign buck_enable    = buck_q;
  assign chg_i_mode     = imode_q;
  assign chg_i_code     = icode_q;
  assign cv_mode        = (st_q == ST_CV);
  assign full_v_code    = volt_q[FULL_V_LSB +: 6];
  assign pre_exit_sel   = volt_q[PRE_SEL_BIT];
  assign term_i_code    = chgi_q[TERM_I_LSB +: 4];
  assign sys_min_code   = cfg_q[SYS_MIN_LSB +: 3];
  assign sys_offset_sel = cfg_q[SYS_OFS_BIT];
  assign sys_track_max  = track_q;
  assign batfet_linear  = lin_q;
  assign tj_limit_sel   = thm_q[TJ_LSB +: 2];
  assign thermal_reduce = thr_q;
endmodule

// ### tb/bcs_checker.sv
// Purpose: port-level assertions for the charge sequencer
// Assumes: single pclk domain, presetn async active low
// Notes: pin relations allow for the two-flop synchroniser
`timescale 1ns/10ps
module bcs_checker
  import bcs_pkg::*;
#(
  parameter int unsigned PRE_TO  = 50,
  parameter int unsigned SAFE_TO = 200
) (
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic [11:0]     paddr,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic [NPIN-1:0] pins_async,
  input wire logic            serial_ready,
  input wire logic            power_good,
  input wire logic            dpdm_start,
  input wire logic            buck_enable,
  input wire logic [1:0]      chg_i_mode,
  input wire logic            sys_track_max,
  input wire logic            thermal_reduce
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_always_a: assert property (pready)
    else $error("pready low");
  supply_ready_a: assert property (pins_async[PIN_VIN_UV] [*6] |=> serial_ready)
    else $error("bus not ready with supply up");
  err_access_a: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access");
  err_unmapped_a: assert property (psel && penable && paddr == 12'h01c |-> pslverr)
    else $error("unmapped access not refused");
  pg_headroom_a: assert property (!pins_async[PIN_VIN_HDRM] [*4] |=> !power_good)
    else $error("power good without headroom");
  buck_after_pg_a: assert property ($rose(buck_enable) |-> power_good)
    else $error("converter enabled before power good");
  dpdm_pulse_a: assert property (dpdm_start |=> !dpdm_start)
    else $error("detection start longer than one cycle");
  idle_track_a: assert property (chg_i_mode == IMODE_OFF [*4] |-> sys_track_max)
    else $error("no max tracking while not charging");
  ovp_stop_a: assert property (pins_async[PIN_OVP] [*5] |=> chg_i_mode == IMODE_OFF)
    else $error("charging during overvoltage");
  tj_cool_a: assert property (!pins_async[PIN_TJ_HOT] [*5] |=> !thermal_reduce)
    else $error("thermal reduction while cool");
endmodule
bind bcs_top bcs_checker #(.PRE_TO(PRE_TO), .SAFE_TO(SAFE_TO)) chk (
  .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .pins_async,
  .serial_ready, .power_good, .dpdm_start, .buck_enable, .chg_i_mode,
  .sys_track_max, .thermal_reduce
);

// ### tb/bcs_power_model.sv
// Purpose: battery and source comparators for the charge sequencer
// Assumes: voltages in millivolts, thresholds are plain defaults
// Notes: purely combinational, the design synchronises the pins
`timescale 1ns/10ps
module bcs_power_model
  import bcs_pkg::*;
#(
  parameter int FULL_MV   = 4200,
  parameter int PRE_MV    = 3000,
  parameter int RECHG_MV  = 4100,
  parameter int SYSMIN_MV = 3500
) (
  input  wire logic [15:0]     vin_mv,
  input  wire logic [15:0]     vbat_mv,
  input  wire logic            ichg_low,
  input  wire logic            ntc_bad,
  input  wire logic            tj_hot,
  input  wire logic            permit_n,
  output logic      [NPIN-1:0] pins
);
  // comparator bank; thresholds fixed so expectations stay simple
  always_comb begin
    pins               = '0;
    pins[PIN_VIN_UV]   = vin_mv > 16'd3800;
    pins[PIN_BAT_UV]   = vbat_mv > 16'd2500;
    pins[PIN_VIN_HDRM] = vin_mv > vbat_mv + 16'd250;
    pins[PIN_SHORT]    = vbat_mv < 16'd2100;
    pins[PIN_PRE_EXIT] = vbat_mv > PRE_MV;
    pins[PIN_FULL]     = vbat_mv >= FULL_MV;
    pins[PIN_TERM]     = ichg_low;
    pins[PIN_RECHG]    = vbat_mv < RECHG_MV;
    pins[PIN_OVP]      = vbat_mv > FULL_MV + 160;
    pins[PIN_SYSMIN]   = vbat_mv < SYSMIN_MV + 60;
    pins[PIN_NTC]      = ntc_bad;
    pins[PIN_PERMIT_N] = permit_n;
    pins[PIN_TJ_HOT]   = tj_hot;
  end
endmodule

// ### tb/tb_battery_charge_sequencer.sv
// Purpose: self-checking bench for the charge sequencer
// Assumes: short timeouts, pins settle within six cycles
// Notes: one idle cycle between apb transfers
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module tb_battery_charge_sequencer;
  import bcs_pkg::*;
  localparam int unsigned PRE_T = 50;
  localparam int unsigned SAFE_T = 200;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, slverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [15:0] vin, vbat;
  logic ichg_low, ntc_bad, tj_hot, permit_n, power_good, buck_enable, cv_mode;
  logic sys_track_max, thermal_reduce, sys_offset_sel;
  logic serial_ready, dpdm_start, pre_exit_sel, batfet_linear;
  logic [5:0] full_v_code;
  logic [3:0] term_i_code;
  logic [2:0] sys_min_code;
  logic [1:0] tj_limit_sel;
  logic [NPIN-1:0] pins;
  logic [1:0] chg_i_mode;
  logic [5:0] chg_i_code;
  int num_errors = 0;
  int checks_done = 0;
  logic [11:0] ra [6] = '{12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018};
  logic [7:0] rv [6] = '{RST_SYS_CFG, RST_FAST_I, RST_CHG_I, RST_VOLT, RST_TIMER, RST_THERM};
  bcs_top #(.PRE_TO(PRE_T), .SAFE_TO(SAFE_T)) uut (
    .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pins_async(pins), .serial_ready, .power_good, .dpdm_start,
    .buck_enable, .chg_i_mode, .chg_i_code, .cv_mode, .full_v_code, .pre_exit_sel,
    .term_i_code, .sys_min_code, .sys_offset_sel, .sys_track_max,
    .batfet_linear, .tj_limit_sel, .thermal_reduce);
  bcs_power_model pm (.vin_mv(vin), .vbat_mv(vbat), .ichg_low, .ntc_bad, .tj_hot,
    .permit_n, .pins);
  // free-running 100 MHz clock
  always #5 pclk = ~pclk;
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one apb transfer; request held until pready seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin num_errors++; test_done(); end
    rdata = prdata; slverr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // restart by dropping and raising the enable field
  task automatic restart(input logic [7:0] cfg);
    apb(1'b1, 12'h004, 32'h0a); apb(1'b1, 12'h004, {24'h0, cfg}); wt(6);
  endtask
  // guard against a hang
  initial begin wt(60000); num_errors++; test_done(); end
  initial begin
    pclk = 0; presetn = 0; clk_en = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = '0; pwdata = '0; vin = 0; vbat = 0; ichg_low = 0; ntc_bad = 0;
    tj_hot = 0; permit_n = 0;
    wt(20); presetn <= 1'b1;
    wt(2); vin <= 16'd5000; vbat <= 16'd1800; wt(6);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 0); `CHK("reset value", rv[i], rdata[7:0])
    end
    apb(1'b0, 12'h01c, 0); `CHK("unmapped err", 1'b1, slverr)
    `CHK("power good", 1'b1, power_good)
    `CHK("buck", 1'b1, buck_enable)
    `CHK("trickle", IMODE_TRK, chg_i_mode)
    `CHK("track max", 1'b1, sys_track_max)
    `CHK("serial ready", 1'b1, serial_ready)
    `CHK("full code", 6'h28, full_v_code)
    `CHK("pre exit sel", 1'b1, pre_exit_sel)
    `CHK("term code", 4'h1, term_i_code)
    `CHK("min code", 3'h5, sys_min_code)
    `CHK("linear", 1'b1, batfet_linear)
    `CHK("tj select", 2'h3, tj_limit_sel)
    apb(1'b1, 12'h020, 32'hff); apb(1'b0, 12'h020, 0);
    `CHK("phase trickle", 3'h1, rdata[7:5])
    vbat <= 16'd2500; restart(8'h1b);
    `CHK("precharge", IMODE_PRE, chg_i_mode)
    `CHK("pre code", 6'h01, chg_i_code)
    `CHK("offset sel", 1'b1, sys_offset_sel)
    wt(PRE_T + 10); apb(1'b0, 12'h020, 0);
    `CHK("pre timeout", 4'hd, {rdata[7:5], rdata[3]})
    `CHK("off after pre", IMODE_OFF, chg_i_mode)
    `CHK("fault track", 1'b1, sys_track_max)
    vbat <= 16'd3800; restart(8'h1a);
    `CHK("fast", IMODE_FAST, chg_i_mode)
    `CHK("fast code", 6'h18, chg_i_code)
    `CHK("battery track", 1'b0, sys_track_max)
    `CHK("linear off", 1'b0, batfet_linear)
    tj_hot <= 1'b1; wt(6); `CHK("thermal", 1'b1, thermal_reduce)
    tj_hot <= 1'b0; wt(SAFE_T + 10); apb(1'b0, 12'h020, 0);
    `CHK("safety timeout", 1'b1, rdata[4])
    restart(8'h1a); vbat <= 16'd4200; wt(6);
    `CHK("cv", 1'b1, cv_mode)
    ichg_low <= 1'b1; wt(6); apb(1'b0, 12'h020, 0);
    `CHK("done phase", 3'h5, rdata[7:5])
    `CHK("done track", 1'b1, sys_track_max)
    // request, start, pre and fast each take an edge after the synchroniser
    ichg_low <= 1'b0; vbat <= 16'd4000; wt(8);
    `CHK("recharge", IMODE_FAST, chg_i_mode)
    vbat <= 16'd4400; wt(6); apb(1'b0, 12'h020, 0);
    `CHK("ovp off", IMODE_OFF, chg_i_mode)
    `CHK("ovp flag", 1'b1, rdata[1])
    `CHK("ovp buck", 1'b1, buck_enable)
    permit_n <= 1'b1; vbat <= 16'd3800; wt(6);
    `CHK("permit high", IMODE_OFF, chg_i_mode)
    permit_n <= 1'b0; apb(1'b1, 12'h004, 32'h2a); wt(6);
    `CHK("otg pg", 1'b0, power_good)
    `CHK("otg off", IMODE_OFF, chg_i_mode)
    // detection enabled and battery switch forced off, then power good returns
    apb(1'b1, 12'h018, 32'hc3);
    apb(1'b1, 12'h004, 32'h1a);
    wt(2);
    `CHK("detect pulse", 1'b1, dpdm_start)
    wt(1);
    `CHK("detect end", 1'b0, dpdm_start)
    wt(6);
    `CHK("forced off", IMODE_OFF, chg_i_mode)
    apb(1'b1, 12'h018, 32'h83);
    wt(6);
    `CHK("forced off released", IMODE_FAST, chg_i_mode)
    // input falls under its undervoltage level while charging
    vin <= 16'd3700;
    wt(6);
    `CHK("input lost pg", 1'b0, power_good)
    `CHK("input lost off", IMODE_OFF, chg_i_mode)
    test_done();
  end
endmodule
